//--- hdl/lcq_ddr_latency_table.sv
// DDR read latency query table: serial byte read port plus a latency lookup for the read engine.
// Assumes sck, csN and sdi come from an external host (SPI mode 0) and are async to mclk;
// the lookup inputs are on the mclk domain.
// Operation
// - First byte is table identifier 9Ah
// - Length 2Ah, five rows of eight
// - Header row starts with F, C
// - Fast DDR read opcodes 0Dh, 0Eh
// - Dual I/O DDR opcodes BDh, BEh
// - Quad I/O DDR opcodes EDh, EEh
// - 50 MHz code 11b: 4,4,3 latency
// - 66 MHz code 00b: 5,6,6 latency
// - 66 MHz code 01b: 6,7,7 latency
// - 66 MHz code 10b: 7,8,8 latency
// - Quad DDR one mode cycle, others none
// - Row bytes: frequency MHz, then code
`timescale 1ns/1ns
module lcq_ddr_latency_table
    import lcq_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       sck,
    input  wire logic       csN,
    input  wire logic       sdi,
    output logic            sdo,
    output logic            sdoOe,
    input  wire logic [7:0] cmdOpcode,
    input  wire logic [1:0] latencyCode,
    input  wire logic [7:0] sckFreqMhz,
    input  wire logic       lookupReq,
    output logic            lookupDone,
    output logic            lookupHit,
    output logic            cmdAddr4,
    output logic      [7:0] modeCycles,
    output logic      [7:0] latencyCycles
);
    import lcq_pkg::*;

    // Opcode classification, shared by hit and cycle decode; is_addr4 decodes the address width
    function automatic lcq_cmd_t cmd_class(input logic [7:0] opc);
        case (opc)
            LCQ_OPC_FAST3, LCQ_OPC_FAST4: cmd_class = CMD_FAST;
            LCQ_OPC_DUAL3, LCQ_OPC_DUAL4: cmd_class = CMD_DUAL;
            LCQ_OPC_QUAD3, LCQ_OPC_QUAD4: cmd_class = CMD_QUAD;
            default:                      cmd_class = CMD_NONE;
        endcase
    endfunction

    function automatic logic is_addr4(input logic [7:0] opc);
        is_addr4 = (opc == LCQ_OPC_FAST4) || (opc == LCQ_OPC_DUAL4) || (opc == LCQ_OPC_QUAD4);
    endfunction

    // Pin synchronisers: stage one feeds stage two only
    logic [2:0] sckMeta_ff, nxt_sckMeta;
    logic [1:0] csMeta_ff,  nxt_csMeta;
    logic [1:0] sdiMeta_ff, nxt_sdiMeta;
    logic       sckRise, sckFall, csIdle, sdiBit;

    always_comb begin
        nxt_sckMeta = {sckMeta_ff[1:0], sck};
        nxt_csMeta  = {csMeta_ff[0], csN};
        nxt_sdiMeta = {sdiMeta_ff[0], sdi};
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sckMeta_ff <= 3'h0;
            csMeta_ff  <= 2'h3;
            sdiMeta_ff <= 2'h0;
        end else begin
            sckMeta_ff <= nxt_sckMeta;
            csMeta_ff  <= nxt_csMeta;
            sdiMeta_ff <= nxt_sdiMeta;
        end
    end

    assign sckRise = sckMeta_ff[1] & ~sckMeta_ff[2];
    assign sckFall = ~sckMeta_ff[1] & sckMeta_ff[2];
    assign csIdle  = csMeta_ff[1];
    assign sdiBit  = sdiMeta_ff[1];

    // Serial query read: 8-bit offset in, then bytes out from that offset onward
    lcq_state_t state_ff, nxt_state;
    logic [7:0] addrSh_ff, nxt_addrSh;
    logic [7:0] ptr_ff,    nxt_ptr;
    logic [7:0] dataSh_ff, nxt_dataSh;
    logic [2:0] bitCnt_ff, nxt_bitCnt;
    logic       sdo_ff,    nxt_sdo;
    logic       sdoOe_ff,  nxt_sdoOe;
    logic [7:0] romOffset, romByte;

    // Offset of the byte about to be loaded into the shifter
    assign romOffset = (state_ff == ST_ADDR) ? {addrSh_ff[6:0], sdiBit} : ptr_ff + 8'h01;

    lcq_table_rom u_rom (
        .offset   (romOffset),
        .dataByte (romByte)
    );

    always_comb begin
        nxt_state  = state_ff;
        nxt_addrSh = addrSh_ff;
        nxt_ptr    = ptr_ff;
        nxt_dataSh = dataSh_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_sdo    = sdo_ff;
        nxt_sdoOe  = sdoOe_ff;
        if (csIdle) begin
            // Deselect aborts any frame; the host restarts with a new offset
            nxt_state  = ST_ADDR;
            nxt_bitCnt = 3'h0;
            nxt_sdoOe  = 1'b0;
            nxt_sdo    = 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (sckRise) begin
                        nxt_addrSh = {addrSh_ff[6:0], sdiBit};
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (bitCnt_ff == LCQ_BIT_LAST) begin
                            nxt_ptr    = romOffset;
                            nxt_dataSh = romByte;
                            nxt_state  = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    // Data changes on falling sck so the host samples it on the rising one
                    if (sckFall) begin
                        nxt_sdoOe  = 1'b1;
                        nxt_sdo    = dataSh_ff[7];
                        nxt_dataSh = {dataSh_ff[6:0], 1'b0};
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (bitCnt_ff == LCQ_BIT_LAST) begin
                            nxt_ptr    = romOffset;
                            nxt_dataSh = romByte;
                        end
                    end
                end
                default: nxt_state = ST_ADDR;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff  <= ST_ADDR;
            addrSh_ff <= 8'h00;
            ptr_ff    <= 8'h00;
            dataSh_ff <= 8'h00;
            bitCnt_ff <= 3'h0;
            sdo_ff    <= 1'b0;
            sdoOe_ff  <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            addrSh_ff <= nxt_addrSh;
            ptr_ff    <= nxt_ptr;
            dataSh_ff <= nxt_dataSh;
            bitCnt_ff <= nxt_bitCnt;
            sdo_ff    <= nxt_sdo;
            sdoOe_ff  <= nxt_sdoOe;
        end
    end

    assign sdo   = sdo_ff;
    assign sdoOe = sdoOe_ff;

    // Latency lookup: first row whose limit covers the clock and whose code matches
    logic       done_ff,  nxt_done;
    logic       hit_ff,   nxt_hit;
    logic       addr4_ff, nxt_addr4;
    logic [7:0] mode_ff,  nxt_mode;
    logic [7:0] lat_ff,   nxt_lat;
    lcq_cmd_t   cls;
    logic       found;

    always_comb begin
        cls       = cmd_class(cmdOpcode);
        found     = 1'b0;
        nxt_done  = lookupReq;
        nxt_hit   = hit_ff;
        nxt_addr4 = addr4_ff;
        nxt_mode  = mode_ff;
        nxt_lat   = lat_ff;
        if (lookupReq) begin
            nxt_hit   = 1'b0;
            nxt_addr4 = is_addr4(cmdOpcode);
            nxt_mode  = 8'h00;
            nxt_lat   = 8'h00;
            for (int r = 0; r < LCQ_DATA_ROWS; r++) begin
                if (!found && cls != CMD_NONE && sckFreqMhz <= LCQ_ROW_FREQ[r]
                    && latencyCode == LCQ_ROW_CODE[r]) begin
                    found   = 1'b1;
                    nxt_hit = 1'b1;
                    case (cls)
                        CMD_FAST: begin
                            nxt_mode = LCQ_MODE_FAST;
                            nxt_lat  = LCQ_LAT_FAST[r];
                        end
                        CMD_DUAL: begin
                            nxt_mode = LCQ_MODE_DUAL;
                            nxt_lat  = LCQ_LAT_DUAL[r];
                        end
                        default: begin
                            nxt_mode = LCQ_MODE_QUAD;
                            nxt_lat  = LCQ_LAT_QUAD[r];
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            done_ff  <= 1'b0;
            hit_ff   <= 1'b0;
            addr4_ff <= 1'b0;
            mode_ff  <= 8'h00;
            lat_ff   <= 8'h00;
        end else begin
            done_ff  <= nxt_done;
            hit_ff   <= nxt_hit;
            addr4_ff <= nxt_addr4;
            mode_ff  <= nxt_mode;
            lat_ff   <= nxt_lat;
        end
    end

    assign lookupDone    = done_ff;
    assign lookupHit     = hit_ff;
    assign cmdAddr4      = addr4_ff;
    assign modeCycles    = mode_ff;
    assign latencyCycles = lat_ff;

endmodule

//--- hdl/lcq_pkg.sv
// Constants of the DDR read latency query table and its serial read port.
// Assumes a single 50 MHz system clock; the table contents are fixed at build time.
package lcq_pkg;

    // Parameter header bytes
    localparam logic [7:0] LCQ_PARAM_ID  = 8'h9A;
    localparam logic [7:0] LCQ_PARAM_LEN = 8'h2A;
    localparam logic [7:0] LCQ_ROW_COUNT = 8'h05;
    localparam logic [7:0] LCQ_ROW_LEN   = 8'h08;
    localparam logic [7:0] LCQ_HDR_FREQ  = 8'h46;
    localparam logic [7:0] LCQ_HDR_CODE  = 8'h43;

    // Command opcodes carried in the header row
    localparam logic [7:0] LCQ_OPC_FAST3 = 8'h0D;
    localparam logic [7:0] LCQ_OPC_FAST4 = 8'h0E;
    localparam logic [7:0] LCQ_OPC_DUAL3 = 8'hBD;
    localparam logic [7:0] LCQ_OPC_DUAL4 = 8'hBE;
    localparam logic [7:0] LCQ_OPC_QUAD3 = 8'hED;
    localparam logic [7:0] LCQ_OPC_QUAD4 = 8'hEE;

    // Byte offsets within the parameter
    localparam logic [7:0] LCQ_OFS_ID     = 8'h00;
    localparam logic [7:0] LCQ_OFS_LEN    = 8'h01;
    localparam logic [7:0] LCQ_OFS_ROWS   = 8'h02;
    localparam logic [7:0] LCQ_OFS_ROWLEN = 8'h03;
    localparam logic [7:0] LCQ_OFS_HDRF   = 8'h04;
    localparam logic [7:0] LCQ_OFS_HDRC   = 8'h05;
    localparam logic [7:0] LCQ_OFS_OPC    = 8'h06;
    localparam logic [7:0] LCQ_OFS_ROW2   = 8'h0C;
    localparam logic [7:0] LCQ_TABLE_END  = 8'h2C;
    localparam logic [7:0] LCQ_FILL_BYTE  = 8'h00;

    // Data rows (rows 2 to 5)
    localparam int         LCQ_DATA_ROWS = 4;
    localparam logic [7:0] LCQ_ROW_FREQ  [LCQ_DATA_ROWS] = '{8'h32, 8'h42, 8'h42, 8'h42};
    localparam logic [1:0] LCQ_ROW_CODE  [LCQ_DATA_ROWS] = '{2'h3, 2'h0, 2'h1, 2'h2};
    localparam logic [7:0] LCQ_LAT_FAST  [LCQ_DATA_ROWS] = '{8'h04, 8'h05, 8'h06, 8'h07};
    localparam logic [7:0] LCQ_LAT_DUAL  [LCQ_DATA_ROWS] = '{8'h04, 8'h06, 8'h07, 8'h08};
    localparam logic [7:0] LCQ_LAT_QUAD  [LCQ_DATA_ROWS] = '{8'h03, 8'h06, 8'h07, 8'h08};
    localparam logic [7:0] LCQ_MODE_FAST = 8'h00;
    localparam logic [7:0] LCQ_MODE_DUAL = 8'h00;
    localparam logic [7:0] LCQ_MODE_QUAD = 8'h01;

    // Serial port
    localparam logic [2:0] LCQ_BIT_LAST  = 3'h7;

    typedef enum logic [1:0] {CMD_NONE, CMD_FAST, CMD_DUAL, CMD_QUAD} lcq_cmd_t;
    typedef enum {ST_ADDR, ST_DATA} lcq_state_t;

endpackage

//--- hdl/lcq_table_rom.sv
// Byte lookup of the DDR latency query parameter.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module lcq_table_rom
    import lcq_pkg::*;
(
    input  wire logic [7:0] offset,
    output logic      [7:0] dataByte
);
    logic [7:0] rel;
    logic [1:0] row;

    always_comb begin
        rel = offset - LCQ_OFS_ROW2;
        row = rel[4:3];
        dataByte = LCQ_FILL_BYTE;
        if (offset < LCQ_OFS_ROW2) begin
            case (offset)
                LCQ_OFS_ID:         dataByte = LCQ_PARAM_ID;
                LCQ_OFS_LEN:        dataByte = LCQ_PARAM_LEN;
                LCQ_OFS_ROWS:       dataByte = LCQ_ROW_COUNT;
                LCQ_OFS_ROWLEN:     dataByte = LCQ_ROW_LEN;
                LCQ_OFS_HDRF:       dataByte = LCQ_HDR_FREQ;
                LCQ_OFS_HDRC:       dataByte = LCQ_HDR_CODE;
                LCQ_OFS_OPC:        dataByte = LCQ_OPC_FAST3;
                LCQ_OFS_OPC + 8'h1: dataByte = LCQ_OPC_FAST4;
                LCQ_OFS_OPC + 8'h2: dataByte = LCQ_OPC_DUAL3;
                LCQ_OFS_OPC + 8'h3: dataByte = LCQ_OPC_DUAL4;
                LCQ_OFS_OPC + 8'h4: dataByte = LCQ_OPC_QUAD3;
                LCQ_OFS_OPC + 8'h5: dataByte = LCQ_OPC_QUAD4;
                default:            dataByte = LCQ_FILL_BYTE;
            endcase
        end else if (offset < LCQ_TABLE_END) begin
            case (rel[2:0])
                3'h0:    dataByte = LCQ_ROW_FREQ[row];
                3'h1:    dataByte = {6'h00, LCQ_ROW_CODE[row]};
                3'h2:    dataByte = LCQ_MODE_FAST;
                3'h3:    dataByte = LCQ_LAT_FAST[row];
                3'h4:    dataByte = LCQ_MODE_DUAL;
                3'h5:    dataByte = LCQ_LAT_DUAL[row];
                3'h6:    dataByte = LCQ_MODE_QUAD;
                default: dataByte = LCQ_LAT_QUAD[row];
            endcase
        end
    end
endmodule

//--- dv/lcq_ddr_latency_table_assertions.sv
// Checker for the DDR latency query table: lookup answers and serial output idle state.
// Assumes one mclk domain with synchronous active-high reset; bound onto the top module.
`timescale 1ns/1ns
module lcq_ddr_latency_table_checker
    import lcq_pkg::*;
(
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       csN,
    input wire logic       sdo,
    input wire logic       sdoOe,
    input wire logic [7:0] cmdOpcode,
    input wire logic [1:0] latencyCode,
    input wire logic [7:0] sckFreqMhz,
    input wire logic       lookupReq,
    input wire logic       lookupDone,
    input wire logic       lookupHit,
    input wire logic       cmdAddr4,
    input wire logic [7:0] modeCycles,
    input wire logic [7:0] latencyCycles
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire isQuad = cmdOpcode == LCQ_OPC_QUAD3 || cmdOpcode == LCQ_OPC_QUAD4;

    done_pulse_a: assert property (lookupReq |=> lookupDone)
        else $error("lookup answer missing");
    no_stray_a: assert property (!lookupReq |=> !lookupDone)
        else $error("lookup answer without request");
    answer_hold_a: assert property (
        !lookupReq |=> $stable(latencyCycles) && $stable(lookupHit))
        else $error("lookup result changed without request");
    quad_slow_a: assert property (
        lookupReq && isQuad && latencyCode == 2'h3 && sckFreqMhz <= 8'h32
        |=> lookupHit && modeCycles == 8'h01 && latencyCycles == 8'h03)
        else $error("quad row one wrong");
    fast_code0_a: assert property (
        lookupReq && cmdOpcode == LCQ_OPC_FAST3 && latencyCode == 2'h0 && sckFreqMhz <= 8'h42
        |=> modeCycles == 8'h00 && latencyCycles == 8'h05)
        else $error("fast row wrong");
    dual_code2_a: assert property (
        lookupReq && cmdOpcode == LCQ_OPC_DUAL4 && latencyCode == 2'h2 && sckFreqMhz <= 8'h42
        |=> cmdAddr4 && latencyCycles == 8'h08)
        else $error("dual row wrong");
    over_freq_a: assert property (lookupReq && sckFreqMhz > 8'h42 |=> !lookupHit)
        else $error("hit above every frequency limit");
    miss_zero_a: assert property (lookupDone && !lookupHit |-> modeCycles == 8'h00
        && latencyCycles == 8'h00) else $error("miss carries cycles");
    idle_off_a: assert property (csN [*6] |-> !sdoOe && !sdo)
        else $error("serial output driven while deselected");

    cover property (lookupDone && lookupHit && modeCycles == 8'h01);
    cover property (lookupDone && !lookupHit);
    cover property ($rose(sdoOe));
endmodule
bind lcq_ddr_latency_table lcq_ddr_latency_table_checker chk (.mclk(mclk), .reset(reset),
    .csN(csN), .sdo(sdo), .sdoOe(sdoOe), .cmdOpcode(cmdOpcode), .latencyCode(latencyCode),
    .sckFreqMhz(sckFreqMhz), .lookupReq(lookupReq), .lookupDone(lookupDone),
    .lookupHit(lookupHit), .cmdAddr4(cmdAddr4), .modeCycles(modeCycles),
    .latencyCycles(latencyCycles));

//--- dv/lcq_spi_host.sv
// Host model of the serial query port: mode 0 master, 160 ns serial clock.
// Assumes the bench calls frame() and then reads the bytes collected in got.
`timescale 1ns/1ns
module lcq_spi_host (
    output logic      sck,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdo
);
    logic [7:0] got [$];
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end
    task automatic frame(input logic [7:0] ofs, input int nBits, input int nBytes);
        logic [7:0] v;
        got.delete();
        csN = 1'b0;
        #100;
        for (int i = 0; i < nBits; i++) begin
            sdi = ofs[7 - i];
            #80 sck = 1'b1;
            #80 sck = 1'b0;
        end
        // Released line shows the opposite level, never a stale bit
        sdi = ~sdi;
        for (int b = 0; b < nBytes; b++) begin
            for (int j = 0; j < 8; j++) begin
                #80 sck = 1'b1;
                // Sampled late: the synchronised output trails the falling edge
                #80 v = {v[6:0], sdo};
                sck = 1'b0;
            end
            got.push_back(v);
        end
        #40 csN = 1'b1;
        #200;
    endtask
endmodule

//--- dv/test_lcq_ddr_latency_table.sv
// Bench for the DDR latency query table: lookup port and serial reads of the image.
// Assumes the host model drives the serial pins and the checker is bound to the block.
`timescale 1ns/1ns
module test_lcq_ddr_latency_table;
    import lcq_pkg::*;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       sck, csN, sdi, sdo, sdoOe, lookupDone, lookupHit, cmdAddr4;
    logic [7:0] cmdOpcode = 8'h00;
    logic [1:0] latencyCode = 2'h0;
    logic [7:0] sckFreqMhz = 8'h00;
    logic       lookupReq = 1'b0;
    logic [7:0] modeCycles, latencyCycles;
    wire        sdoLine = sdoOe ? sdo : 1'bz;
    int         n_mismatch = 0;
    int         checked = 0;
    // Expected image plus two fill bytes past its end
    logic [7:0] tbl [46] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43, 8'h0D, 8'h0E, 8'hBD,
        8'hBE, 8'hED, 8'hEE, 8'h32, 8'h03, 8'h00, 8'h04, 8'h00, 8'h04, 8'h01, 8'h03, 8'h42,
        8'h00, 8'h00, 8'h05, 8'h00, 8'h06, 8'h01, 8'h06, 8'h42, 8'h01, 8'h00, 8'h06, 8'h00,
        8'h07, 8'h01, 8'h07, 8'h42, 8'h02, 8'h00, 8'h07, 8'h00, 8'h08, 8'h01, 8'h08, 8'h00,
        8'h00};
    always #10 mclk = ~mclk;
    lcq_ddr_latency_table dut (.mclk(mclk), .reset(reset), .sck(sck), .csN(csN), .sdi(sdi),
        .sdo(sdo), .sdoOe(sdoOe), .cmdOpcode(cmdOpcode), .latencyCode(latencyCode),
        .sckFreqMhz(sckFreqMhz), .lookupReq(lookupReq), .lookupDone(lookupDone),
        .lookupHit(lookupHit), .cmdAddr4(cmdAddr4), .modeCycles(modeCycles),
        .latencyCycles(latencyCycles));
    lcq_spi_host host (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdoLine));
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Leaves the request raised so consecutive calls land on consecutive edges
    task automatic look(input logic [7:0] op, input logic [1:0] c, input logic [7:0] f,
                        input logic h, input logic [7:0] m, input logic [7:0] l);
        cmdOpcode = op;
        latencyCode = c;
        sckFreqMhz = f;
        lookupReq = 1'b1;
        @(posedge mclk) #2;
        cmp("done", 8'h01, {7'h00, lookupDone});
        cmp("hit", {7'h00, h}, {7'h00, lookupHit});
        if (h) cmp("addr4", {7'h00, ~op[0]}, {7'h00, cmdAddr4});
        cmp("mode", m, modeCycles);
        cmp("latency", l, latencyCycles);
    endtask
    task automatic lookup_rows;
        logic [7:0] opc [6] = '{8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
        @(posedge mclk) #2;
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 6; k++) begin
                int         b = 14 + 8 * r + k / 2 * 2;
                logic [1:0] c = tbl[13 + 8 * r][1:0];
                logic [7:0] f = tbl[12 + 8 * r];
                look(opc[k], c, f, 1'b1, tbl[b], tbl[b + 1]);
                look(opc[k], c, 8'h01, 1'b1, tbl[b], tbl[b + 1]);
            end
        end
        lookupReq = 1'b0;
    endtask
    task automatic lookup_misses;
        @(posedge mclk) #2;
        look(8'h0B, 2'h3, 8'h32, 1'b0, 8'h00, 8'h00);
        look(8'hEE, 2'h3, 8'h33, 1'b0, 8'h00, 8'h00);
        look(8'h0D, 2'h0, 8'h43, 1'b0, 8'h00, 8'h00);
        lookupReq = 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic read_image;
        // Host steps are whole mclk periods, so this keeps every pin change off the edge
        @(posedge mclk) #2;
        host.frame(8'h00, 8, 46);
        for (int i = 0; i < 46; i++) cmp("image", tbl[i], host.got[i]);
    endtask
    task automatic read_abort_wrap;
        host.frame(8'h0C, 5, 0);
        host.frame(8'h0C, 8, 1);
        cmp("after abort", 8'h32, host.got[0]);
        host.frame(8'hFF, 8, 2);
        cmp("wrap fill", 8'h00, host.got[0]);
        cmp("wrap id", 8'h9A, host.got[1]);
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge mclk);
        #2 reset = 1'b0;
        lookup_rows();
        lookup_misses();
        read_image();
        read_abort_wrap();
        test_done();
    end
endmodule
